// [rtl/dpr_pkg.sv]
// constants, codes and types of the DSI packet receiver
// What this block does
// - size field low byte first, limit honoured
// - command read: code byte, second byte 00
// - after turnaround answer error report or data
// - long null packet accepted, payload discarded
// - identifier: channel 00 high, type low
// - end packet: type 08, 0F 0F, check 01
// - missing end packet in HS flags violation once one has been seen
// - accept transfers with or without end packet
// - never send end packet, reply low-power only
// - decode four sync event types
// - vertical sync events imply horizontal starts
// - type 12 enters eight-colour mode
// - type 02 leaves eight-colour mode
// - type 22 display off, receiver stays alive
// - type 32 turns display back on
// - blanking packets accepted as timing only
// - type 0E unpacks 5-6-5 pixels LSB first
// - type 1E routed to pixel unpacker
// - packets with header errors are discarded; checksum errors are only reported
// - 18-bit packed unpacks 6-6-6 LSB first
package dpr_pkg;

  // ==========================================================================
  // packet identifier fields
  localparam logic [1:0]  VC_OWN         = 2'h0;
  localparam logic [5:0]  DT_VS_START    = 6'h01;
  localparam logic [5:0]  DT_VS_END      = 6'h11;
  localparam logic [5:0]  DT_HS_START    = 6'h21;
  localparam logic [5:0]  DT_HS_END      = 6'h31;
  localparam logic [5:0]  DT_COLOR8_OFF  = 6'h02;
  localparam logic [5:0]  DT_COLOR8_ON   = 6'h12;
  localparam logic [5:0]  DT_SHUTDOWN    = 6'h22;
  localparam logic [5:0]  DT_TURN_ON     = 6'h32;
  localparam logic [5:0]  DT_EOTP        = 6'h08;
  localparam logic [5:0]  DT_RET_SIZE    = 6'h37;
  localparam logic [5:0]  DT_CMD_READ    = 6'h06;
  localparam logic [5:0]  DT_CMD_WR0     = 6'h05;
  localparam logic [5:0]  DT_CMD_WR1     = 6'h15;
  localparam logic [5:0]  DT_GEN_RD1     = 6'h14;
  localparam logic [5:0]  DT_NULL        = 6'h09;
  localparam logic [5:0]  DT_BLANK       = 6'h19;
  localparam logic [5:0]  DT_GEN_LONG    = 6'h29;
  localparam logic [5:0]  DT_CMD_LONG    = 6'h39;
  localparam logic [5:0]  DT_PIX16       = 6'h0E;
  localparam logic [5:0]  DT_PIX18       = 6'h1E;
  localparam logic [5:0]  DT_ACK_ERR     = 6'h02;
  localparam logic [5:0]  DT_RD_RESP1    = 6'h21;

  // ==========================================================================
  // fixed field values
  localparam logic [7:0]  EOTP_DATA      = 8'h0F;
  localparam logic [7:0]  EOTP_ECC       = 8'h01;
  localparam logic [7:0]  READ_PAD       = 8'h00;
  localparam logic [15:0] RET_SIZE_RST   = 16'h0000;
  localparam logic        COLOR8_RST     = 1'b0;
  localparam logic        DISP_ON_RST    = 1'b1;

  // ==========================================================================
  // error report bit positions
  localparam int          ERR_ECC_MULTI  = 9;
  localparam int          ERR_CRC        = 10;
  localparam int          ERR_DT         = 11;
  localparam int          ERR_VC         = 12;
  localparam int          ERR_LEN        = 13;
  localparam int          ERR_PROTO      = 15;

  // ==========================================================================
  // header check and payload checksum
  localparam logic [23:0] ECC_M0         = 24'hF12CB7;
  localparam logic [23:0] ECC_M1         = 24'hF2555B;
  localparam logic [23:0] ECC_M2         = 24'h749A6D;
  localparam logic [23:0] ECC_M3         = 24'hB8E38E;
  localparam logic [23:0] ECC_M4         = 24'hDF03F0;
  localparam logic [23:0] ECC_M5         = 24'hEFFC00;
  localparam logic [15:0] CRC_POLY       = 16'h8408;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;

  // ==========================================================================
  // pixel packing
  localparam logic [4:0]  PIX16_BITS     = 5'h10;
  localparam logic [4:0]  PIX18_BITS     = 5'h12;
  localparam logic [4:0]  BYTE_BITS      = 5'h08;

  typedef enum logic [2:0] {ST_HDR, ST_PAY, ST_CRC, ST_SKIP, ST_RSP} dpr_state_t;

endpackage

// [rtl/dpr_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module dpr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and filtered result
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a bit only moves once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end
endmodule

// [rtl/dpr_fifo.sv]
// two-entry pixel buffer with registered outputs
`timescale 1ns/1ps
module dpr_fifo #(
  parameter int W = 18
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] tail_q;
  logic         tail_v_q;
  logic         push;
  logic         pop;

  assign in_ready = ~tail_v_q;
  assign push     = in_valid & ~tail_v_q;
  assign pop      = out_valid & out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
      tail_q    <= '0;
      tail_v_q  <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!out_valid) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
          end else begin
            tail_q   <= in_data;
            tail_v_q <= 1'b1;
          end
        end
        2'b01: begin
          if (tail_v_q) begin
            out_data <= tail_q;
            tail_v_q <= 1'b0;
          end else begin
            out_valid <= 1'b0;
          end
        end
        2'b11: begin
          out_data <= in_data;
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// [rtl/dpr_rx.sv]
// DSI packet receiver: header decode, commands, pixel unpack, turnaround reply
`timescale 1ns/1ps
module dpr_rx
  import dpr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link pins, all outside the clock domain
  input  wire logic        link_clk,
  input  wire logic        link_frame,
  input  wire logic        link_hs,
  input  wire logic        link_bta,
  input  wire logic [7:0]  link_data,
  // configuration pin
  input  wire logic        hs_end_packet_check_disable,
  // sync events
  output logic             vs_start,
  output logic             vs_end,
  output logic             hs_start,
  output logic             hs_end,
  // display control state
  output logic             color8_mode,
  output logic             display_on,
  output logic             blanking,
  // read request toward the display core
  output logic [7:0]       read_first_id_command,
  input  wire logic [7:0]  read_data,
  // pixel stream
  output logic             pix_valid,
  output logic [17:0]      pix_data,
  input  wire logic        pix_ready,
  output logic             pix_overrun,
  // low-power return path
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_lp,
  input  wire logic        tx_ready
);

  // ==========================================================================
  // helpers
  function automatic logic [5:0] ecc6(input logic [23:0] d);
    ecc6 = {^(d & ECC_M5), ^(d & ECC_M4), ^(d & ECC_M3),
            ^(d & ECC_M2), ^(d & ECC_M1), ^(d & ECC_M0)};
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // returns {known, long}
  function automatic logic [1:0] dt_class(input logic [5:0] dt);
    case (dt)
      DT_NULL, DT_BLANK, DT_GEN_LONG, DT_CMD_LONG, DT_PIX16, DT_PIX18:
        dt_class = 2'h3;
      DT_VS_START, DT_VS_END, DT_HS_START, DT_HS_END, DT_EOTP, DT_RET_SIZE,
      DT_CMD_READ, DT_CMD_WR0, DT_CMD_WR1, DT_GEN_RD1, DT_COLOR8_ON,
      DT_COLOR8_OFF, DT_SHUTDOWN, DT_TURN_ON:
        dt_class = 2'h2;
      default:
        dt_class = 2'h0;
    endcase
  endfunction

  // ==========================================================================
  // pin synchronisation and link edge detection
  logic [12:0] sy;
  logic        lclk;
  logic        frame;
  logic        hs;
  logic        bta;
  logic        chk_dis;
  logic [7:0]  ldat;
  logic        lclk_q;
  logic        frame_q;
  logic        bta_q;
  logic        frame_hs_q;
  logic        byte_stb;
  logic        frame_fall;
  logic        bta_rise;

  dpr_sync #(.W(13)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({hs_end_packet_check_disable, link_clk, link_frame, link_hs,
           link_bta, link_data}),
    .q   (sy)
  );

  assign chk_dis    = sy[12];
  assign lclk       = sy[11];
  assign frame      = sy[10];
  assign hs         = sy[9];
  assign bta        = sy[8];
  assign ldat       = sy[7:0];
  assign byte_stb   = lclk & ~lclk_q & frame;
  assign frame_fall = ~frame & frame_q;
  assign bta_rise   = bta & ~bta_q;

  // mode is taken at the frame start; the host holds it for the whole burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lclk_q     <= 1'b0;
      frame_q    <= 1'b0;
      bta_q      <= 1'b0;
      frame_hs_q <= 1'b0;
    end else begin
      lclk_q  <= lclk;
      frame_q <= frame;
      bta_q   <= bta;
      if (frame & ~frame_q) begin
        frame_hs_q <= hs;
      end
    end
  end

  // ==========================================================================
  // header decode
  dpr_state_t  st_q;
  logic [1:0]  idx_q;
  logic [23:0] hdr_q;
  logic [15:0] wc_q;
  logic [5:0]  dt_q;
  logic [5:0]  dt_in;
  logic [7:0]  hdr_b1;
  logic [7:0]  hdr_b2;
  logic [1:0]  cls;
  logic        ecc_ok;
  logic        vc_ok;
  logic        hdr_done;
  logic        hdr_good;
  logic        cmd_stb;
  logic        rsp_start;
  logic        tx_done;
  logic [1:0]  txi_q;

  assign dt_in     = hdr_q[5:0];
  assign hdr_b1    = hdr_q[15:8];
  assign hdr_b2    = hdr_q[23:16];
  assign cls       = dt_class(dt_in);
  assign vc_ok     = hdr_q[7:6] == VC_OWN;
  assign ecc_ok    = (ldat[7:6] == 2'h0) && (ecc6(hdr_q) == ldat[5:0]);
  assign hdr_done  = byte_stb && (st_q == ST_HDR) && (idx_q == 2'h3);
  assign hdr_good  = ecc_ok && vc_ok && cls[1];
  assign cmd_stb   = hdr_done && hdr_good;
  assign rsp_start = (st_q == ST_HDR) && (idx_q == 2'h0) && bta_rise && !frame_fall;
  assign tx_done   = (st_q == ST_RSP) && tx_valid && tx_ready && (txi_q == 2'h3);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdr_q <= '0;
    end else if (byte_stb && (st_q == ST_HDR)) begin
      case (idx_q)
        2'h0:    hdr_q[7:0]   <= ldat;
        2'h1:    hdr_q[15:8]  <= ldat;
        2'h2:    hdr_q[23:16] <= ldat;
        default: hdr_q        <= hdr_q;
      endcase
    end
  end

  // ==========================================================================
  // packet framing
  // a bad header leaves the length unknown, so the rest of the burst is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= ST_HDR;
      idx_q <= 2'h0;
      wc_q  <= '0;
      dt_q  <= '0;
    end else begin
      case (st_q)
        ST_HDR: begin
          if (frame_fall) begin
            idx_q <= 2'h0;
          end else if (byte_stb) begin
            if (idx_q == 2'h3) begin
              idx_q <= 2'h0;
              dt_q  <= dt_in;
              wc_q  <= hdr_q[23:8];
              if (!hdr_good) begin
                st_q <= ST_SKIP;
              end else if (cls[0]) begin
                st_q <= (hdr_q[23:8] == 16'h0000) ? ST_CRC : ST_PAY;
              end
            end else begin
              idx_q <= idx_q + 2'h1;
            end
          end else if (rsp_start) begin
            st_q <= ST_RSP;
          end
        end
        ST_PAY: begin
          if (frame_fall) begin
            st_q <= ST_HDR;
          end else if (byte_stb) begin
            wc_q <= wc_q - 16'h0001;
            if (wc_q == 16'h0001) begin
              st_q <= ST_CRC;
            end
          end
        end
        ST_CRC: begin
          if (frame_fall) begin
            st_q  <= ST_HDR;
            idx_q <= 2'h0;
          end else if (byte_stb) begin
            if (idx_q == 2'h0) begin
              idx_q <= 2'h1;
            end else begin
              idx_q <= 2'h0;
              st_q  <= ST_HDR;
            end
          end
        end
        ST_SKIP: begin
          if (frame_fall) begin
            st_q <= ST_HDR;
          end
        end
        ST_RSP: begin
          if (tx_done) begin
            st_q <= ST_HDR;
          end
        end
        default: st_q <= ST_HDR;
      endcase
    end
  end

  // ==========================================================================
  // payload checksum
  logic [15:0] crc_q;
  logic [7:0]  crc_lo_q;
  logic        crc_bad;

  assign crc_bad = byte_stb && (st_q == ST_CRC) && (idx_q == 2'h1)
                   && ({ldat, crc_lo_q} != crc_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q    <= CRC_INIT;
      crc_lo_q <= '0;
    end else if (hdr_done) begin
      crc_q <= CRC_INIT;
    end else if (byte_stb && (st_q == ST_PAY)) begin
      crc_q <= crc_step(crc_q, ldat);
    end else if (byte_stb && (st_q == ST_CRC) && (idx_q == 2'h0)) begin
      crc_lo_q <= ldat;
    end
  end

  // ==========================================================================
  // end-of-transmission tracking
  logic eotp_used_q;
  logic last_eotp_q;
  logic is_eotp;
  logic eot_miss;

  assign is_eotp  = hdr_good && (dt_in == DT_EOTP) && (hdr_b1 == EOTP_DATA)
                    && (hdr_b2 == EOTP_DATA) && (ldat == EOTP_ECC);
  // low-power bursts never demand the end packet
  assign eot_miss = frame_fall && frame_hs_q && eotp_used_q && !last_eotp_q
                    && !chk_dis;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eotp_used_q <= 1'b0;
      last_eotp_q <= 1'b0;
    end else if (hdr_done) begin
      last_eotp_q <= is_eotp;
      if (is_eotp) begin
        eotp_used_q <= 1'b1;
      end
    end else if (frame_fall) begin
      last_eotp_q <= 1'b0;
    end
  end

  // ==========================================================================
  // error report of the last packet
  logic [15:0] err_q;
  logic [15:0] hdr_err;
  logic        len_short;

  assign len_short = frame_fall && ((st_q == ST_PAY) || (st_q == ST_CRC)
                     || ((st_q == ST_HDR) && (idx_q != 2'h0)));

  always_comb begin
    hdr_err                = '0;
    hdr_err[ERR_ECC_MULTI] = ~ecc_ok;
    hdr_err[ERR_VC]        = ~vc_ok;
    hdr_err[ERR_DT]        = ~cls[1];
  end

  // clear first, so an error seen in the same cycle survives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= '0;
    end else if (hdr_done) begin
      err_q <= hdr_err;
    end else begin
      if (tx_done) begin
        err_q <= '0;
      end
      if (crc_bad) begin
        err_q[ERR_CRC] <= 1'b1;
      end
      if (len_short) begin
        err_q[ERR_LEN] <= 1'b1;
      end
      if (eot_miss) begin
        err_q[ERR_PROTO] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // short commands and sync events
  logic [15:0] ret_limit_q;
  logic        rd_pend_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vs_start <= 1'b0;
      vs_end   <= 1'b0;
      hs_start <= 1'b0;
      hs_end   <= 1'b0;
    end else begin
      vs_start <= cmd_stb && (dt_in == DT_VS_START);
      vs_end   <= cmd_stb && (dt_in == DT_VS_END);
      hs_start <= cmd_stb && ((dt_in == DT_HS_START) || (dt_in == DT_VS_START)
                  || (dt_in == DT_VS_END));
      hs_end   <= cmd_stb && (dt_in == DT_HS_END);
    end
  end

  // the receiver never powers down, so a turn-on always gets through
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      color8_mode <= COLOR8_RST;
      display_on  <= DISP_ON_RST;
    end else if (cmd_stb) begin
      case (dt_in)
        DT_COLOR8_ON:  color8_mode <= 1'b1;
        DT_COLOR8_OFF: color8_mode <= 1'b0;
        DT_SHUTDOWN:   display_on  <= 1'b0;
        DT_TURN_ON:    display_on  <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_limit_q           <= RET_SIZE_RST;
      rd_pend_q             <= 1'b0;
      read_first_id_command <= '0;
    end else begin
      if (tx_done) begin
        rd_pend_q <= 1'b0;
      end
      if (cmd_stb && (dt_in == DT_RET_SIZE)) begin
        ret_limit_q <= {hdr_b2, hdr_b1};
      end
      if (cmd_stb && (dt_in == DT_CMD_READ) && (hdr_b2 == READ_PAD)) begin
        rd_pend_q             <= 1'b1;
        read_first_id_command <= hdr_b1;
      end
    end
  end

  // ==========================================================================
  // blanking and null payloads only mark time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blanking <= 1'b0;
    end else begin
      blanking <= (st_q == ST_PAY) && (dt_q == DT_BLANK);
    end
  end

  // ==========================================================================
  // pixel unpacker: bits arrive LSB first, so an accumulator shifts down
  logic [25:0] acc_q;
  logic [4:0]  cnt_q;
  logic [25:0] acc_b;
  logic [4:0]  cnt_b;
  logic [4:0]  need;
  logic        pix_pay;
  logic        push;
  logic        push_rdy;
  logic [17:0] pix_w;

  assign pix_pay = (dt_q == DT_PIX16) || (dt_q == DT_PIX18);
  assign need    = (dt_q == DT_PIX16) ? PIX16_BITS : PIX18_BITS;
  assign push    = pix_pay && (cnt_q >= need);

  always_comb begin
    if (dt_q == DT_PIX16) begin
      pix_w = {acc_q[4:0], acc_q[4], acc_q[10:5], acc_q[15:11], acc_q[15]};
    end else begin
      pix_w = {acc_q[5:0], acc_q[11:6], acc_q[17:12]};
    end
    if (push && push_rdy) begin
      acc_b = (dt_q == DT_PIX16) ? (acc_q >> 16) : (acc_q >> 18);
      cnt_b = cnt_q - need;
    end else begin
      acc_b = acc_q;
      cnt_b = cnt_q;
    end
  end

  // a stalled sink holds one pixel here; only a second stalled pixel is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q       <= '0;
      cnt_q       <= '0;
      pix_overrun <= 1'b0;
    end else if (hdr_done) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (byte_stb && (st_q == ST_PAY) && pix_pay) begin
      if (cnt_b >= need) begin
        acc_q       <= acc_b;
        cnt_q       <= cnt_b;
        pix_overrun <= 1'b1;
      end else begin
        acc_q <= acc_b | ({18'h00000, ldat} << cnt_b);
        cnt_q <= cnt_b + BYTE_BITS;
      end
    end else begin
      acc_q <= acc_b;
      cnt_q <= cnt_b;
    end
  end

  dpr_fifo #(.W(18)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_data   (pix_w),
    .in_ready  (push_rdy),
    .out_valid (pix_valid),
    .out_data  (pix_data),
    .out_ready (pix_ready)
  );

  // ==========================================================================
  // reply after turnaround, low-power only and never an end packet
  logic [15:0] rsp_err;
  logic [23:0] rsp_d;
  logic [31:0] rsp_q;

  always_comb begin
    rsp_err = err_q;
    if ((err_q == 16'h0000) && rd_pend_q && (ret_limit_q == 16'h0000)) begin
      rsp_err[ERR_LEN] = 1'b1;
    end
    if ((rsp_err != 16'h0000) || !rd_pend_q) begin
      rsp_d = {rsp_err, VC_OWN, DT_ACK_ERR};
    end else begin
      rsp_d = {READ_PAD, read_data, VC_OWN, DT_RD_RESP1};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
      tx_lp    <= 1'b0;
      txi_q    <= 2'h0;
      rsp_q    <= '0;
    end else if (rsp_start) begin
      rsp_q    <= {2'h0, ecc6(rsp_d), rsp_d};
      tx_data  <= rsp_d[7:0];
      tx_valid <= 1'b1;
      tx_lp    <= 1'b1;
      txi_q    <= 2'h0;
    end else if (tx_valid && tx_ready) begin
      if (txi_q == 2'h3) begin
        tx_valid <= 1'b0;
        tx_lp    <= 1'b0;
      end else begin
        tx_data <= rsp_q[15:8];
        rsp_q   <= rsp_q >> 8;
        txi_q   <= txi_q + 2'h1;
      end
    end
  end

endmodule

// [dv/dpr_rx_properties.sv]
// assertion checker on the packet receiver ports
`timescale 1ns/1ps
module dpr_rx_properties (
  input wire logic        clk, rst, link_frame, link_bta, vs_start, vs_end, hs_start,
  input wire logic        color8_mode, display_on, pix_valid, pix_ready,
  input wire logic        tx_valid, tx_lp, tx_ready,
  input wire logic [17:0] pix_data,
  input wire logic [7:0]  tx_data
);
  // ====================
  // port relations
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_TX_LP: assert property (tx_valid |-> tx_lp) else $error("reply not low-power");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held");
  AST_TX_TYPE: assert property ($rose(tx_valid) |-> tx_data == 8'h02 || tx_data == 8'h21)
    else $error("bad reply type");
  AST_BTA_REPLY: assert property ($rose(link_bta) && !link_frame |-> ##[1:12] tx_valid)
    else $error("no reply");
  AST_VS_HS: assert property (vs_start || vs_end |-> hs_start) else $error("no line start");
  AST_VS_PULSE: assert property (vs_start |=> !vs_start) else $error("long pulse");
  AST_MODE_FRAME: assert property ($changed({color8_mode, display_on}) |-> link_frame)
    else $error("mode change outside frame");
  AST_PIX_HOLD: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("pixel not held");
endmodule

bind dpr_rx dpr_rx_properties u_props (.*);

// [dv/dpr_host_model.sv]
// host link transmitter model
`timescale 1ns/1ps
module dpr_host_model
  import dpr_pkg::*;
(
  output logic       link_clk, link_frame, link_hs,
  output logic [7:0] link_data
);
  localparam logic [23:0] M [6] = '{ECC_M0, ECC_M1, ECC_M2, ECC_M3, ECC_M4, ECC_M5};
  initial {link_clk, link_frame, link_hs, link_data} = '0;
  // ====================
  // clock stands still between frames; released data is inverted
  function automatic logic [7:0] ecc(input logic [23:0] h);
    ecc = 8'h00;
    for (int i = 0; i < 6; i++) ecc[i] = ^(h & M[i]);
  endfunction
  task automatic put(input logic [7:0] b);
    link_data = b;
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask
  task automatic sp(input logic [5:0] dt, input logic [7:0] a, b, f);
    put({VC_OWN, dt});
    put(a);
    put(b);
    put(ecc({b, a, VC_OWN, dt}) ^ f);
  endtask
  task automatic fb(input logic hs);
    link_hs = hs;
    #40 link_frame = 1'b1;
    #80;
  endtask
  task automatic fe();
    #80 link_frame = 1'b0;
    link_data = ~link_data;
    #400;
  endtask
endmodule

// [dv/tb_dpr_rx.sv]
// self-checking bench for the packet receiver
`timescale 1ns/1ps
module tb_dpr_rx;
  import dpr_pkg::*;
  logic        clk, rst, link_clk, link_frame, link_hs, link_bta, hs_end_packet_check_disable;
  logic        vs_start, vs_end, hs_start, hs_end, color8_mode, display_on, blanking, bl;
  logic        pix_valid, pix_ready, pix_overrun, tx_valid, tx_lp, tx_ready, stall;
  logic [7:0]  link_data, read_first_id_command, read_data, tx_data, e;
  logic [17:0] pix_data;
  logic [71:0] s;
  logic [31:0] x;
  logic [17:0] pq [$];
  logic [7:0]  rq [$];
  int          n_mismatch = 0, check_count = 0, n_vs = 0, n_ve = 0, n_hs = 0, n_he = 0;
  localparam logic [7:0] CMD [4] = '{{DT_COLOR8_ON, 2'b11}, {DT_COLOR8_OFF, 2'b01},
                                    {DT_SHUTDOWN, 2'b00}, {DT_TURN_ON, 2'b01}};
  localparam logic [5:0] SYN [4] = '{DT_VS_START, DT_VS_END, DT_HS_START, DT_HS_END};

  dpr_rx DUT (.*);
  dpr_host_model H (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====================
  // helpers
  function automatic logic [7:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x[7:0];
  endfunction
  function automatic logic [17:0] p16(input logic [15:0] w);
    return {w[4:0], w[4], w[10:5], w[15:11], w[15]};
  endfunction
  function automatic logic [17:0] p18(input int k);
    return {s[18*k+:6], s[18*k+6+:6], s[18*k+12+:6]};
  endfunction
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // hand the bus over and collect the four reply bytes
  task automatic turn_around();
    rq.delete();
    @(negedge clk) link_bta = 1'b1;
    for (int i = 0; i < 300 && rq.size() < 4; i++) @(posedge clk);
    @(negedge clk) link_bta = 1'b0;
  endtask
  // checksum left wrong on purpose: it only raises an error bit
  task automatic lng(input logic [5:0] dt, input int n);
    H.sp(dt, 8'(n), 8'h00, 8'h00);
    for (int i = 0; i < n; i++) begin
      s[i*8+:8] = rnd();
      H.put(s[i*8+:8]);
    end
    H.put(8'hA5);
    H.put(8'h5A);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ====================
  // random stalls and monitors
  always @(negedge clk) begin
    pix_ready <= !stall && rnd() > 8'h50;
    tx_ready  <= rnd() > 8'h60;
  end
  always @(posedge clk) begin
    n_vs += vs_start;
    n_ve += vs_end;
    n_hs += hs_start;
    n_he += hs_end;
    if (blanking) bl = 1'b1;
    if (pix_valid && pix_ready) pq.push_back(pix_data);
    if (tx_valid && tx_ready) rq.push_back(tx_data);
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  // ====================
  // scenarios
  initial begin
    {rst, link_bta, stall, bl, hs_end_packet_check_disable, read_data} = 13'h1000;
    x = 32'h1A;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk(color8_mode === 1'b0 && display_on === 1'b1, "reset levels");
    read_data = rnd();
    H.fb(1'b1);
    H.sp(DT_RET_SIZE, 8'h01, 8'h00, 8'h00);
    H.sp(DT_CMD_READ, 8'hDA, READ_PAD, 8'h00);
    H.sp(DT_EOTP, EOTP_DATA, EOTP_DATA, 8'h00);
    H.fe();
    chk(read_first_id_command === 8'hDA, "read command");
    turn_around();
    chk(rq.size() == 4 && rq[0] === 8'h21 && rq[1] === read_data, "reply head");
    chk(rq[2] === 8'h00 && rq[3] === H.ecc({8'h00, read_data, 8'h21}), "reply tail");
    // high-speed burst without end packet, report enabled then suppressed
    for (int i = 0; i < 2; i++) begin
      hs_end_packet_check_disable = i[0];
      e = i[0] ? 8'h00 : 8'h80;
      H.fb(1'b1);
      H.sp(DT_RET_SIZE, 8'h01, 8'h00, 8'h00);
      H.fe();
      turn_around();
      chk(rq.size() == 4 && rq[0] === 8'h02 && rq[2] === e, "eot report");
      chk(rq[1] === 8'h00 && rq[3] === H.ecc({e, 8'h00, 8'h02}), "report tail");
    end
    H.fb(1'b0);
    H.sp(DT_COLOR8_ON, 8'h00, 8'h00, 8'h03);
    H.fe();
    chk(color8_mode === 1'b0, "bad header acted on");
    foreach (CMD[i]) begin
      H.fb(1'b0);
      H.sp(CMD[i][7:2], 8'h00, 8'h00, 8'h00);
      H.fe();
      chk({color8_mode, display_on} === CMD[i][1:0], "display mode");
    end
    H.fb(1'b1);
    foreach (SYN[i]) H.sp(SYN[i], 8'h00, 8'h00, 8'h00);
    lng(DT_BLANK, 2);
    lng(DT_NULL, 3);
    lng(DT_PIX16, 2);
    H.fe();
    chk(n_vs == 1 && n_ve == 1 && n_hs == 3 && n_he == 1, "sync events");
    chk(bl === 1'b1 && pq.size() == 1 && pq[0] === p16(s[15:0]), "long packets");
    stall = 1'b1;
    H.fb(1'b1);
    lng(DT_PIX18, 9);
    H.fe();
    chk(pix_overrun === 1'b1, "no overrun");
    stall = 1'b0;
    repeat (20) @(negedge clk);
    chk(pq.size() >= 3 && pq[1] === p18(0) && pq[2] === p18(1), "packed pixels");
    close_out();
  end
endmodule
